/* bench/mbp_asserts.sv */
// Checker for the backoff, pacing, pause and hash block.
// Sees only the top ports; bound to mbp_top at the foot.
`timescale 1ns/1ps
module mbp_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [47:0] dest_addr,
	input wire logic group_accept,
	input wire logic [5:0] group_hash_value,
	input wire logic tx_collision,
	input wire logic tx_deferred,
	input wire logic tx_frame_done,
	input wire logic tx_frame_start,
	input wire logic backoff_busy,
	input wire logic tx_gap_hold,
	input wire logic pause_sent,
	input wire logic [15:0] pause_sent_time,
	input wire logic pause_send_req
);
	// ==========================================
	// Gap length counter
	logic [9:0] gap_len_ff, nxt_gap_len;
	always_comb begin
		nxt_gap_len = tx_gap_hold ? gap_len_ff + 10'h001 : 10'h000;
	end
	always_ff @(posedge clk) begin
		gap_len_ff <= rst ? 10'h000 : nxt_gap_len;
	end
	function automatic logic [5:0] fold(input logic [47:0] a);
		fold = 6'h00;
		for (int i = 0; i < 48; i++)
			fold[i % 6] ^= a[i];
	endfunction : fold
	// Unmapped places read as all reserved
	function automatic logic [31:0] rmask(input logic [7:0] a);
		case (a)
			mbp_pkg::ADDR_HASH_LOWER, mbp_pkg::ADDR_HASH_UPPER: rmask = 32'h0000_0000;
			mbp_pkg::ADDR_BACKOFF: rmask = 32'hFC00_0C00;
			mbp_pkg::ADDR_PACING: rmask = 32'hFFFF_FFE0;
			mbp_pkg::ADDR_RX_PAUSE: rmask = 32'hFFFF_0000;
			default: rmask = 32'hFFFF_FFFF;
		endcase
	endfunction : rmask
	// ==========================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_up_wr; reg_wr && reg_addr == mbp_pkg::ADDR_HASH_UPPER; endsequence
	sequence s_up_rd; reg_rd && reg_addr == mbp_pkg::ADDR_HASH_UPPER; endsequence
	property p_hash_rb; s_up_wr ##1 s_up_rd |=> reg_rdata == $past(reg_wdata, 2); endproperty
	a_hash_rb: assert property (p_hash_rb) else $error("upper half readback");
	property p_fold; group_hash_value == fold(dest_addr); endproperty
	a_fold: assert property (p_fold) else $error("hash fold");
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_rsvd; $past(reg_rd) |-> (reg_rdata & rmask($past(reg_addr))) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_busy; $rose(backoff_busy) |-> $past(tx_collision); endproperty
	a_busy: assert property (p_busy) else $error("backoff without collision");
	property p_gap_go; tx_frame_done |=> tx_gap_hold; endproperty
	a_gap_go: assert property (p_gap_go) else $error("no gap after frame");
	property p_gap_len; $fell(tx_gap_hold) |-> gap_len_ff inside {10'h060, 10'h180}; endproperty
	a_gap_len: assert property (p_gap_len) else $error("gap length");
	property p_pause_ld; pause_sent && pause_sent_time == 16'hFFFF |=> !pause_send_req [*8]; endproperty
	a_pause_ld: assert property (p_pause_ld) else $error("request after load");
	property p_req_hold; pause_send_req && !pause_sent |=> pause_send_req; endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
endmodule : mbp_asserts
bind mbp_top mbp_asserts u_chk (.*);

/* bench/mbp_top_tb_top.sv */
// Self-checking bench for mbp_top with the far-side model.
// Assumes 100 MHz clock and back-to-back write then read.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got %0h exp %0h", $time, (a), (e)); end end
module mbp_top_tb_top;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d, e;
	logic [63:0] tbl;
	logic [47:0] dest_addr = 48'h0;
	logic group_accept, backoff_busy, tx_gap_hold, pause_send_req;
	logic [5:0] group_hash_value;
	logic tx_collision, tx_deferred, tx_frame_done, tx_frame_start, pause_sent;
	logic [15:0] pause_sent_time;
	int error_cnt = 0, checks = 0, cyc = 0, n, c;
	mbp_top dut (.*);
	mbp_tx_model u_phy (.*);
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	// Write strobe is dropped by the read that always follows
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	function automatic logic [5:0] fold(input logic [47:0] a);
		fold = 6'h00;
		for (int i = 0; i < 48; i++)
			fold[i % 6] ^= a[i];
	endfunction : fold
	function automatic logic [9:0] lowmask(input int k);
		return (10'h001 << (k > 10 ? 10 : k)) - 10'h001;
	endfunction : lowmask
	task automatic gap(input int len);
		n = 0;
		#1;
		while (tx_gap_hold === 1'b1 && n < 500) begin
			n++;
			@(posedge clk);
			#1;
		end
		`CHK(n, len)
	endtask : gap
	initial begin
		n = $urandom(20);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), d);
			`CHK(d & 32'hFC00_FFFF, 32'h0)
		end
		rd(mbp_pkg::ADDR_BACKOFF, d);
		rd(mbp_pkg::ADDR_BACKOFF, e);
		`CHK(d[25:16] != e[25:16], 1'b1)
		wr(mbp_pkg::ADDR_PACING, 32'hFFFF_FFFF);
		rd(mbp_pkg::ADDR_PACING, d);
		`CHK(d, 32'h0)
		tbl = {$urandom, $urandom};
		wr(mbp_pkg::ADDR_HASH_LOWER, tbl[31:0]);
		rd(mbp_pkg::ADDR_HASH_LOWER, d);
		`CHK(d, tbl[31:0])
		wr(mbp_pkg::ADDR_HASH_UPPER, tbl[63:32]);
		rd(mbp_pkg::ADDR_HASH_UPPER, d);
		`CHK(d, tbl[63:32])
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			dest_addr <= i == 0 ? 48'hFFFF_FFFF_FFFF : 48'({$urandom, $urandom});
			#1 `CHK(group_hash_value, fold(dest_addr))
			`CHK(group_accept, tbl[fold(dest_addr)])
		end
		u_phy.frame(0, 1'b0);
		u_phy.done();
		gap(96);
		rd(mbp_pkg::ADDR_PACING, d);
		`CHK(d, 32'h0)
		for (int m = 0; m < 2; m++) begin
			c = m ? 0 : $urandom_range(3, 1);
			u_phy.frame(c, m[0]);
			rd(mbp_pkg::ADDR_BACKOFF, d);
			`CHK(d[15:12], 4'(c))
			if (m == 0) begin
				`CHK(d[9:0] & ~lowmask(c), 10'h000)
				`CHK(backoff_busy, d[9:0] != 10'h000)
				repeat (515) @(posedge clk);
				rd(mbp_pkg::ADDR_BACKOFF, e);
				`CHK(e[9:0], d[9:0] - 10'(d[9:0] != 10'h000))
			end
			u_phy.done();
			gap(96);
			rd(mbp_pkg::ADDR_PACING, d);
			`CHK(d, 32'h1F)
		end
		for (int k = 0; k < 2; k++) begin
			u_phy.frame(0, 1'b0);
			u_phy.done();
			gap(384);
			rd(mbp_pkg::ADDR_PACING, d);
			`CHK(d, 32'(30 - k))
		end
		u_phy.frame(17, 1'b0);
		rd(mbp_pkg::ADDR_BACKOFF, d);
		`CHK(d[15:12], 4'hF)
		// Last collision restarted the slot timer, so ticks are known
		u_phy.pause(16'h1234);
		rd(mbp_pkg::ADDR_RX_PAUSE, d);
		`CHK(d, 32'h0)
		u_phy.pause(16'hFFFF);
		rd(mbp_pkg::ADDR_RX_PAUSE, d);
		`CHK(d, 32'h0000_FF00)
		repeat (600) @(posedge clk);
		rd(mbp_pkg::ADDR_RX_PAUSE, d);
		`CHK(d, 32'h0000_FEFF)
		`CHK(pause_send_req, 1'b0)
		u_phy.done();
		gap(96);
		finish_test();
	end
endmodule : mbp_top_tb_top

/* bench/mbp_tx_model.sv */
// Transmit engine and pause source model on the far side.
// Driven by task calls from the bench top.
`timescale 1ns/1ps
module mbp_tx_model (
	input wire logic clk,
	input wire logic tx_gap_hold,
	output logic tx_frame_start = 1'b0,
	output logic tx_collision = 1'b0,
	output logic tx_deferred = 1'b0,
	output logic tx_frame_done = 1'b0,
	output logic pause_sent = 1'b0,
	output logic [15:0] pause_sent_time = 16'h0000
);
	// Start first, then collisions and deferral; done comes separately
	task automatic frame(input int nc, input logic dfr);
		for (int i = 0; i < 1000 && tx_gap_hold !== 1'b0; i++)
			@(posedge clk);
		@(posedge clk) tx_frame_start <= 1'b1;
		@(posedge clk) tx_frame_start <= 1'b0;
		for (int i = 0; i < nc; i++) begin
			@(posedge clk) tx_collision <= 1'b1;
			@(posedge clk) tx_collision <= 1'b0;
		end
		if (dfr) begin
			@(posedge clk) tx_deferred <= 1'b1;
			@(posedge clk) tx_deferred <= 1'b0;
		end
	endtask : frame
	task automatic done();
		@(posedge clk) tx_frame_done <= 1'b1;
		@(posedge clk) tx_frame_done <= 1'b0;
	endtask : done
	// Time is inverted once released, so stale values never match
	task automatic pause(input logic [15:0] t);
		@(posedge clk) pause_sent <= 1'b1;
		pause_sent_time <= t;
		@(posedge clk) pause_sent <= 1'b0;
		pause_sent_time <= ~t;
	endtask : pause
endmodule : mbp_tx_model

/* rtl/mbp_hash.sv */
// Group address hash filter.
// Assumes the destination address is stable while checked.
`timescale 1ns/1ps
module mbp_hash (
	input wire logic [47:0] dest_addr,
	input wire logic [31:0] group_hash_lower,
	input wire logic [31:0] group_hash_upper,
	output logic [5:0] hash_value,
	output logic hash_accept
);
	// ==========================================
	// Fold address bits modulo six
	genvar gi;
	generate
		for (gi = 0; gi < mbp_pkg::HASH_W; gi++) begin : g_fold
			logic acc;
			always_comb begin
				acc = 1'b0;
				for (int k = gi; k < mbp_pkg::DA_W; k += mbp_pkg::HASH_W) begin
					acc = acc ^ dest_addr[k];
				end
			end
			assign hash_value[gi] = acc;
		end
	endgenerate
	// Top hash bit picks the table half
	assign hash_accept = hash_value[5] ? group_hash_upper[hash_value[4:0]]
		: group_hash_lower[hash_value[4:0]];
endmodule : mbp_hash

/* rtl/mbp_pkg.sv */
// Package for the backoff, pacing, pause and hash block.
// Assumes one 100 MHz clock and a plain register port with word-aligned byte offsets.
package mbp_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_HASH_LOWER = 8'h00;
	localparam logic [7:0] ADDR_HASH_UPPER = 8'h04;
	localparam logic [7:0] ADDR_BACKOFF = 8'h08;
	localparam logic [7:0] ADDR_PACING = 8'h0C;
	localparam logic [7:0] ADDR_RX_PAUSE = 8'h10;
	// ==========================================
	// Field layout
	localparam int RND_LSB = 16;
	localparam int COLL_LSB = 12;
	localparam int BOFF_LSB = 0;
	localparam int RND_W = 10;
	localparam int COLL_W = 4;
	localparam int BOFF_W = 10;
	localparam int PACE_W = 5;
	localparam int PAUSE_W = 16;
	localparam int HASH_W = 6;
	localparam int DA_W = 48;
	// ==========================================
	// Values
	localparam logic [31:0] HASH_RESET = 32'h0000_0000;
	localparam logic [PACE_W-1:0] PACE_MAX = 5'h1F;
	localparam logic [PAUSE_W-1:0] PAUSE_RELOAD = 16'hFF00;
	localparam logic [PAUSE_W-1:0] PAUSE_TIME_ALL_ONES = 16'hFFFF;
	localparam logic [RND_W-1:0] LFSR_TAPS = 10'h240;
	localparam logic [3:0] BACKOFF_LIMIT = 4'hA;
	localparam int IPG_STRETCH = 4;
	// ==========================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int SLOT_BIT_TIMES = 512;
	localparam int SLOT_NS = 5120;
	localparam int SLOT_CYCLES = (SLOT_NS * CLK_MHZ + 999) / 1000;
	localparam int IPG_NS = 960;
	localparam int IPG_CYCLES = (IPG_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [2:0] {
		GAP_IDLE = 3'b001,
		GAP_WAIT = 3'b010,
		GAP_DONE = 3'b100
	} mbp_gap_e;
endpackage : mbp_pkg

/* rtl/mbp_slot_timer.sv */
// Slot time tick generator.
// Assumes a free running clock at the package rate.
`timescale 1ns/1ps
module mbp_slot_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	output logic tick
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	always_comb begin
		nxt_cnt = cnt_ff + 16'h0001;
		if (restart || cnt_ff == 16'(mbp_pkg::SLOT_CYCLES - 1)) begin
			nxt_cnt = 16'h0000;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	assign tick = !restart && cnt_ff == 16'(mbp_pkg::SLOT_CYCLES - 1);
endmodule : mbp_slot_timer

/* rtl/mbp_top.sv */
// Backoff, pacing, receive pause and hash filter logic of the MAC.
// Assumes the transmit engine reports collisions, deferrals and frame ends.
// ==========================================
// Summary of operation
// - Upper hash half accepts values 32-63
// - Hash bit i folds address bits modulo six
// - Lower hash half accepts values 0-31
// - Random generator readable at bits 25-16
// - Generator zero in reset, then advances
// - Collision tally readable at bits 15-12
// - Backoff loaded on collision, decrements per slot
// - Collision or deferral loads pacing to 31
// - Clean frame decrements pacing down to zero
// - Pacing active stretches gap to four
// - Deferred or collided frame uses normal gap
// - Pause frame sent with time FFFFh loads timer FF00h
// - Pause timer decrements per slot, readable
// - Timer at zero raises pause request; reload waits for a pause sent with time FFFFh
`timescale 1ns/1ps
module mbp_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [47:0] dest_addr,
	output logic group_accept,
	output logic [5:0] group_hash_value,
	input wire logic tx_collision,
	input wire logic tx_deferred,
	input wire logic tx_frame_done,
	input wire logic tx_frame_start,
	output logic backoff_busy,
	output logic tx_gap_hold,
	input wire logic pause_sent,
	input wire logic [15:0] pause_sent_time,
	output logic pause_send_req
);
	// ==========================================
	// Registers
	logic [31:0] group_hash_lower_ff, nxt_group_hash_lower;
	logic [31:0] group_hash_upper_ff, nxt_group_hash_upper;
	logic [9:0] backoff_random_value_ff, nxt_backoff_random_value;
	logic [3:0] collision_tally_ff, nxt_collision_tally;
	logic [9:0] backoff_countdown_ff, nxt_backoff_countdown;
	logic [4:0] pacing_level_ff, nxt_pacing_level;
	logic [15:0] pause_countdown_ff, nxt_pause_countdown;
	logic pause_active_ff, nxt_pause_active;
	logic pause_send_ff, nxt_pause_send;
	logic [31:0] reg_rdata_ff, nxt_reg_rdata;
	logic last_clean_ff, nxt_last_clean;
	mbp_pkg::mbp_gap_e gap_state_ff, nxt_gap_state;
	logic [9:0] gap_cnt_ff, nxt_gap_cnt;
	logic slot_tick;
	logic [9:0] backoff_mask;
	logic [3:0] mask_bits;

	mbp_hash u_hash (
		.dest_addr(dest_addr),
		.group_hash_lower(group_hash_lower_ff),
		.group_hash_upper(group_hash_upper_ff),
		.hash_value(group_hash_value),
		.hash_accept(group_accept)
	);

	// Slot clock restarts on collision so the first decrement is a full slot later
	mbp_slot_timer u_slot (
		.clk(clk),
		.rst(rst),
		.restart(tx_collision),
		.tick(slot_tick)
	);

	// ==========================================
	// Register port
	always_comb begin
		nxt_group_hash_lower = group_hash_lower_ff;
		nxt_group_hash_upper = group_hash_upper_ff;
		nxt_reg_rdata = 32'h0000_0000;
		if (reg_wr && reg_addr == mbp_pkg::ADDR_HASH_LOWER) begin
			nxt_group_hash_lower = reg_wdata;
		end
		if (reg_wr && reg_addr == mbp_pkg::ADDR_HASH_UPPER) begin
			nxt_group_hash_upper = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				mbp_pkg::ADDR_HASH_LOWER: nxt_reg_rdata = group_hash_lower_ff;
				mbp_pkg::ADDR_HASH_UPPER: nxt_reg_rdata = group_hash_upper_ff;
				mbp_pkg::ADDR_BACKOFF: begin
					nxt_reg_rdata[mbp_pkg::RND_LSB +: mbp_pkg::RND_W] =
						backoff_random_value_ff;
					nxt_reg_rdata[mbp_pkg::COLL_LSB +: mbp_pkg::COLL_W] =
						collision_tally_ff;
					nxt_reg_rdata[mbp_pkg::BOFF_LSB +: mbp_pkg::BOFF_W] =
						backoff_countdown_ff;
				end
				mbp_pkg::ADDR_PACING: nxt_reg_rdata[mbp_pkg::PACE_W-1:0] = pacing_level_ff;
				mbp_pkg::ADDR_RX_PAUSE: nxt_reg_rdata[mbp_pkg::PAUSE_W-1:0] =
					pause_countdown_ff;
				default: nxt_reg_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// Random generator and backoff
	always_comb begin
		nxt_backoff_random_value = {backoff_random_value_ff[8:0],
			~^(backoff_random_value_ff & mbp_pkg::LFSR_TAPS)};
		// Compare before adding: a saturated tally would wrap to zero in four bits
		mask_bits = (collision_tally_ff >= mbp_pkg::BACKOFF_LIMIT) ?
			mbp_pkg::BACKOFF_LIMIT : 4'(collision_tally_ff + 4'h1);
		backoff_mask = 10'(({1'b0, 10'h3FF} >> (mbp_pkg::BACKOFF_LIMIT - mask_bits)));
		nxt_collision_tally = collision_tally_ff;
		nxt_backoff_countdown = backoff_countdown_ff;
		if (tx_collision) begin
			if (collision_tally_ff != 4'hF) begin
				nxt_collision_tally = collision_tally_ff + 4'h1;
			end
			// Truncation at ten keeps the mask inside the counter width
			nxt_backoff_countdown = backoff_random_value_ff & backoff_mask;
		end else begin
			if (slot_tick && backoff_countdown_ff != 10'h000) begin
				nxt_backoff_countdown = backoff_countdown_ff - 10'h001;
			end
			if (tx_frame_done) begin
				nxt_collision_tally = 4'h0;
			end
		end
	end
	assign backoff_busy = backoff_countdown_ff != 10'h000;

	// ==========================================
	// Pacing and gap stretch
	always_comb begin
		nxt_pacing_level = pacing_level_ff;
		nxt_last_clean = last_clean_ff;
		if (tx_collision || tx_deferred) begin
			nxt_pacing_level = mbp_pkg::PACE_MAX;
			nxt_last_clean = 1'b0;
		end else if (tx_frame_done && last_clean_ff) begin
			// Only a frame with no collision or deferral counts down
			if (pacing_level_ff != 5'h00) begin
				nxt_pacing_level = pacing_level_ff - 5'h01;
			end
		end
		if (tx_frame_start) begin
			nxt_last_clean = 1'b1;
		end
	end

	always_comb begin
		nxt_gap_state = gap_state_ff;
		nxt_gap_cnt = gap_cnt_ff;
		case (gap_state_ff)
			mbp_pkg::GAP_IDLE: begin
				if (tx_frame_done) begin
					nxt_gap_state = mbp_pkg::GAP_WAIT;
					// Stretch only after a clean frame while pacing
					if (last_clean_ff && !tx_collision && !tx_deferred
						&& pacing_level_ff != 5'h00) begin
						nxt_gap_cnt = 10'(mbp_pkg::IPG_STRETCH * mbp_pkg::IPG_CYCLES);
					end else begin
						nxt_gap_cnt = 10'(mbp_pkg::IPG_CYCLES);
					end
				end
			end
			mbp_pkg::GAP_WAIT: begin
				if (gap_cnt_ff <= 10'h001) begin
					nxt_gap_state = mbp_pkg::GAP_DONE;
					nxt_gap_cnt = 10'h000;
				end else begin
					nxt_gap_cnt = gap_cnt_ff - 10'h001;
				end
			end
			mbp_pkg::GAP_DONE: nxt_gap_state = mbp_pkg::GAP_IDLE;
			default: nxt_gap_state = mbp_pkg::GAP_IDLE;
		endcase
	end
	assign tx_gap_hold = gap_state_ff == mbp_pkg::GAP_WAIT;

	// ==========================================
	// Receive pause timer
	always_comb begin
		nxt_pause_countdown = pause_countdown_ff;
		nxt_pause_active = pause_active_ff;
		nxt_pause_send = pause_send_ff;
		if (pause_sent && pause_sent_time == mbp_pkg::PAUSE_TIME_ALL_ONES) begin
			nxt_pause_countdown = mbp_pkg::PAUSE_RELOAD;
			nxt_pause_active = 1'b1;
			nxt_pause_send = 1'b0;
		end else if (pause_sent) begin
			nxt_pause_send = 1'b0;
		end else if (pause_active_ff && slot_tick && pause_countdown_ff != 16'h0000) begin
			nxt_pause_countdown = pause_countdown_ff - 16'h0001;
		end else if (pause_active_ff && pause_countdown_ff == 16'h0000) begin
			// Request stays up until the next pause frame goes out
			nxt_pause_send = 1'b1;
		end
	end
	assign pause_send_req = pause_send_ff;

	// ==========================================
	// State registers
	always_ff @(posedge clk) begin
		if (rst) begin
			group_hash_lower_ff <= mbp_pkg::HASH_RESET;
			group_hash_upper_ff <= mbp_pkg::HASH_RESET;
			backoff_random_value_ff <= 10'h000;
			collision_tally_ff <= 4'h0;
			backoff_countdown_ff <= 10'h000;
			pacing_level_ff <= 5'h00;
			last_clean_ff <= 1'b0;
			gap_state_ff <= mbp_pkg::GAP_IDLE;
			gap_cnt_ff <= 10'h000;
			pause_countdown_ff <= 16'h0000;
			pause_active_ff <= 1'b0;
			pause_send_ff <= 1'b0;
			reg_rdata_ff <= 32'h0000_0000;
		end else begin
			group_hash_lower_ff <= nxt_group_hash_lower;
			group_hash_upper_ff <= nxt_group_hash_upper;
			backoff_random_value_ff <= nxt_backoff_random_value;
			collision_tally_ff <= nxt_collision_tally;
			backoff_countdown_ff <= nxt_backoff_countdown;
			pacing_level_ff <= nxt_pacing_level;
			last_clean_ff <= nxt_last_clean;
			gap_state_ff <= nxt_gap_state;
			gap_cnt_ff <= nxt_gap_cnt;
			pause_countdown_ff <= nxt_pause_countdown;
			pause_active_ff <= nxt_pause_active;
			pause_send_ff <= nxt_pause_send;
			reg_rdata_ff <= nxt_reg_rdata;
		end
	end
	assign reg_rdata = reg_rdata_ff;
endmodule : mbp_top
